// >>> dv/mcp_motor_model.sv
/*
 * Far-side model: servo tick source and commutation encoder of the motor.
 * Assumes the bench enables ticks and sets the counts moved per servo cycle.
 */
`default_nettype none
module mcp_motor_model #(
	parameter int TICK_GAP = 40
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic tick_en,
	input wire logic [23:0] step,
	input wire logic [15:0] phase_a_cmd,
	input wire logic [15:0] phase_b_cmd,
	output logic servo_tick,
	output logic [23:0] fb_count
);
	timeunit 1ns;
	timeprecision 1ps;
	int gap;
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			gap <= 0;
			servo_tick <= 1'b0;
			fb_count <= 24'h00_0000;
		end
		else
		begin
			servo_tick <= tick_en && (gap == TICK_GAP - 1);
			gap <= (gap == TICK_GAP - 1) ? 0 : gap + 1;
			// Direct x4 counter, so no 1/32 network scaling; rotor moves only when energised
			if (servo_tick && (phase_a_cmd != 16'h0000 || phase_b_cmd != 16'h0000))
				fb_count <= fb_count + step;
		end
endmodule : mcp_motor_model
`default_nettype wire

// >>> dv/test_motor_commutation_phasing.sv
/*
 * Register-level bench of the commutation and phasing block.
 * Assumes the motor model answers on the feedback side.
 */
`include "mcp_map.svh"
`default_nettype none
`define CHK(got, exp) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("[FAIL] %0t got %h exp %h", $time, got, exp); \
		end \
	end
module test_motor_commutation_phasing;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, reset_n, avs_read, avs_write, avs_waitrequest, servo_tick, phasing_active;
	logic tick_en;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, v;
	logic [15:0] torque_cmd, phase_a_cmd, phase_b_cmd, pa0, pb0;
	logic [23:0] fb_count;
	int n_fail, checks_done, cyc, n;
	logic [7:0] spc [4] = '{8'h55, 8'hab, 8'h40, 8'hc0};

	mcp_top u_mcp_top (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .servo_tick(servo_tick), .fb_count(fb_count),
		.torque_cmd(torque_cmd), .phase_a_cmd(phase_a_cmd), .phase_b_cmd(phase_b_cmd),
		.phasing_active(phasing_active));
	mcp_motor_model u_mcp_motor_model (.clock(clock), .reset_n(reset_n), .tick_en(tick_en),
		.step(24'h00_0025), .phase_a_cmd(phase_a_cmd), .phase_b_cmd(phase_b_cmd),
		.servo_tick(servo_tick), .fb_count(fb_count));

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task complete_run;
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_fail++;
			complete_run();
		end
	end

	// Request held until waitrequest is seen low at an edge; one idle edge follows
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do
			@(posedge clock);
		while (avs_waitrequest !== 1'b0);
		v = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask : bus

	task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		`CHK(v, exp)
	endtask : rd_chk

	// Counts servo ticks while a search runs; optionally checks the stepper lock output
	task automatic search(input bit stepper);
		n = 0;
		repeat (20)
			if (phasing_active !== 1'b1)
				@(posedge clock);
		`CHK(phasing_active, 1'b1)
		while (phasing_active === 1'b1 && n < 600)
		begin
			@(posedge clock);
			if (servo_tick === 1'b1)
				n++;
			if (stepper && n == 10)
			begin
				`CHK(phase_a_cmd, 16'h07d0)
				`CHK(phase_b_cmd, 16'hf830)
			end
		end
	endtask : search

	initial
	begin
		reset_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_writedata = 32'h0000_0000;
		torque_cmd = 16'h1000;
		tick_en = 1'b1;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		rd_chk(`MCP_A_CYCLES, 32'h0000_0001);
		rd_chk(`MCP_A_COUNTS, 32'h0000_03e8);
		rd_chk(`MCP_A_SPACING, 32'h0000_0055);
		rd_chk(`MCP_A_MAG, 32'h0000_0000);
		rd_chk(`MCP_A_DWELL, 32'h0000_0000);
		repeat (40) @(posedge clock);
		rd_chk(`MCP_A_LEN, 32'h0000_03e8);
		rd_chk(`MCP_A_STATUS, 32'h0000_000c);
		bus(1'b1, `MCP_A_DWELL, 32'h0000_0003);
		bus(1'b1, `MCP_A_MAG, 32'h0000_07d0);
		bus(1'b1, `MCP_A_CTRL, 32'h0000_0003);
		search(1'b0);
		`CHK(n >= 5 && n <= 7, 1'b1)
		rd_chk(`MCP_A_STATUS, 32'h0000_000e);
		bus(1'b1, `MCP_A_CTRL, 32'h0000_0000);
		bus(1'b1, `MCP_A_CTRL, 32'h0000_0001);
		repeat (100) @(posedge clock);
		`CHK(phasing_active, 1'b0)
		bus(1'b1, `MCP_A_CTRL, 32'h0000_0011);
		search(1'b0);
		`CHK(n >= 5 && n <= 7, 1'b1)
		bus(1'b1, `MCP_A_DWELL, 32'h0000_0001);
		// Spacing below 128 and no current loop, so the lock magnitude stays positive
		bus(1'b1, `MCP_A_CTRL, 32'h0000_0015);
		search(1'b1);
		`CHK(n >= 510 && n <= 514, 1'b1)
		bus(1'b1, `MCP_A_DWELL, 32'h0000_00ff);
		rd_chk(`MCP_A_DWELL, 32'h0000_00ff);
		tick_en <= 1'b0;
		// Angle result may lag two divider runs behind the position reset
		foreach (spc[i])
		begin
			bus(1'b1, `MCP_A_SPACING, {24'h00_0000, spc[i]});
			rd_chk(`MCP_A_SPACING, {24'h00_0000, spc[i]});
			repeat (80) @(posedge clock);
			if (i == 0 || i == 2)
			begin
				pa0 = phase_a_cmd;
				pb0 = phase_b_cmd;
			end
			else
			begin
				`CHK(phase_a_cmd, pa0)
				`CHK(phase_b_cmd !== pb0, 1'b1)
			end
		end
		bus(1'b1, `MCP_A_CYCLES, 32'h0000_01ff);
		rd_chk(`MCP_A_CYCLES, 32'h0000_00ff);
		bus(1'b1, `MCP_A_COUNTS, 32'hffff_ffff);
		rd_chk(`MCP_A_COUNTS, 32'h007f_ffff);
		bus(1'b1, `MCP_A_CYCLES, 32'h0000_0000);
		repeat (40) @(posedge clock);
		rd_chk(`MCP_A_STATUS, 32'h0000_0006);
		bus(1'b1, `MCP_A_CYCLES, 32'h0000_0003);
		bus(1'b1, `MCP_A_COUNTS, 32'h0000_1000);
		// A division begun on the old settings is dropped, so allow two full runs
		repeat (80) @(posedge clock);
		rd_chk(`MCP_A_LEN, 32'h0000_0555);
		bus(1'b1, 6'h3f, 32'h1234_5678);
		rd_chk(6'h3f, 32'h0000_0000);
		// Current loop selected with spacing above 128: sensors read positive into a phase
		bus(1'b1, `MCP_A_CTRL, 32'h0000_000d);
		rd_chk(`MCP_A_CTRL, 32'h0000_000d);
		bus(1'b1, `MCP_A_CYCLES, 32'h0000_0001);
		bus(1'b1, `MCP_A_COUNTS, 32'h0000_03e8);
		tick_en <= 1'b1;
		repeat (1800) @(posedge clock);
		bus(1'b0, `MCP_A_POS, 32'h0000_0000);
		`CHK(v < 32'h0000_03e8, 1'b1)
		complete_run();
	end
endmodule : test_motor_commutation_phasing
`default_nettype wire

// >>> pkg/mcp_map.svh
/*
 * Register offsets, field positions, reset values and counts of the
 * commutation and phasing block. Assumes a 32-bit Avalon-MM register port.
 */
`ifndef MCP_MAP_SVH
`define MCP_MAP_SVH

`define MCP_A_CTRL 6'h00
`define MCP_A_CYCLES 6'h01
`define MCP_A_COUNTS 6'h02
`define MCP_A_SPACING 6'h03
`define MCP_A_MAG 6'h04
`define MCP_A_DWELL 6'h05
`define MCP_A_ABS 6'h06
`define MCP_A_SLIP 6'h07
`define MCP_A_STATUS 6'h08
`define MCP_A_LEN 6'h09
`define MCP_A_POS 6'h0a

`define MCP_B_ENABLE 0
`define MCP_B_MODE_LO 1
`define MCP_B_MODE_HI 2
`define MCP_B_CLOOP 3
`define MCP_B_PHASE_CMD 4

`define MCP_RST_CYCLES 8'h01
`define MCP_RST_COUNTS 23'h00_03e8
`define MCP_RST_SPACING 8'h55
`define MCP_RST_MAG 16'h0000
`define MCP_RST_DWELL 8'h00
`define MCP_GUESS_B 8'h40
`define MCP_WAVE_SHIFT 12
`define MCP_DIV_STEPS 6'h20

`endif

// >>> pkg/mcp_pkg.sv
/*
 * Types of the commutation and phasing block.
 * Assumes mcp_map.svh for all numeric constants.
 */
`default_nettype none
package mcp_pkg;
	typedef enum logic [2:0] {
		MCP_IDLE,
		MCP_GUESS1,
		MCP_GUESS2,
		MCP_STEP_A,
		MCP_STEP_B
	} mcp_phase_t;

	typedef struct packed {
		logic wait_n;
		logic [31:0] rdata;
		logic en;
		logic [1:0] mode;
		logic cloop;
		logic [7:0] cyc;
		logic [22:0] cnts;
		logic [7:0] spc;
		logic [15:0] mag;
		logic [7:0] dwell;
		logic [15:0] abs_addr;
		logic [22:0] slip;
		logic [23:0] len;
		logic len_ok;
		logic [23:0] pos;
		logic [23:0] fb_last;
		logic [23:0] fb_mark;
		logic m1_neg;
		logic [7:0] ang;
		logic [7:0] ofs;
		mcp_phase_t st;
		logic [15:0] tmr;
		logic phased;
		logic armed;
		logic cmd;
		logic [15:0] pa;
		logic [15:0] pb;
		logic srch;
	} mcp_state_t;

	typedef struct packed {
		logic busy;
		logic done;
		logic [5:0] cnt;
		logic [24:0] rem;
		logic [31:0] quo;
		logic [23:0] dvs;
	} mcp_div_st_t;
endpackage : mcp_pkg
`default_nettype wire

// >>> rtl/mcp_div.sv
/*
 * Sequential restoring divider, one quotient bit per clock.
 * Assumes start is only honoured while not busy.
 */
`include "mcp_map.svh"
`default_nettype none
module mcp_div
	import mcp_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [31:0] dividend,
	input wire logic [23:0] divisor,
	output logic busy,
	output logic done,
	output logic [31:0] quot
);
	mcp_div_st_t s_q, s_d;
	logic [24:0] trial;

	always_comb
	begin
		s_d = s_q;
		trial = {s_q.rem[23:0], s_q.quo[31]};
		s_d.done = 1'b0;
		if (s_q.busy)
		begin
			// A zero divisor yields all ones; the length caller rejects it, the angle caller only checks len_ok
			if (trial >= {1'b0, s_q.dvs})
			begin
				s_d.rem = trial - {1'b0, s_q.dvs};
				s_d.quo = {s_q.quo[30:0], 1'b1};
			end
			else
			begin
				s_d.rem = trial;
				s_d.quo = {s_q.quo[30:0], 1'b0};
			end
			s_d.cnt = s_q.cnt - 6'h01;
			if (s_q.cnt == 6'h01)
			begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end
		end
		else if (start)
		begin
			s_d.busy = 1'b1;
			s_d.cnt = `MCP_DIV_STEPS;
			s_d.rem = 25'h000_0000;
			s_d.quo = dividend;
			s_d.dvs = divisor;
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign busy = s_q.busy;
	assign done = s_q.done;
	assign quot = s_q.quo;
endmodule : mcp_div
`default_nettype wire

// >>> rtl/mcp_top.sv
/*
 * Commutation and power-on phasing search for one motor: cycle length,
 * wrapped phase position, phase outputs and two search methods.
 * Assumes servo_tick is a one-cycle pulse per servo cycle and fb_count is
 * the decoded commutation feedback counter, synchronous to clock.
 */
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`include "mcp_map.svh"
`default_nettype none
module mcp_top
	import mcp_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic avs_waitrequest,
	output logic [31:0] avs_readdata,
	input wire logic servo_tick,
	input wire logic [23:0] fb_count,
	input wire logic [15:0] torque_cmd,
	output logic [15:0] phase_a_cmd,
	output logic [15:0] phase_b_cmd,
	output logic phasing_active
);
	mcp_state_t s_q, s_d;
	logic d1_busy, d1_done, d2_busy, d2_done;
	logic [31:0] d1_quot, d2_quot;
	logic [31:0] wd;
	logic acc, wr, need, go;
	logic [24:0] np;
	logic [23:0] delta;
	logic [7:0] drive_ang;
	logic [15:0] drive_mag;

	// Magnitude times a parabolic sine of the electrical angle
	function automatic logic [15:0] mcp_wave(input logic [7:0] a, input logic [15:0] m);
		logic [12:0] y;
		logic [29:0] p;
		y = 13'(a[6:0]) * (13'h0080 - 13'(a[6:0]));
		p = 30'($signed(m) * $signed({1'b0, y}));
		p = 30'($signed(p) >>> `MCP_WAVE_SHIFT);
		mcp_wave = a[7] ? 16'(-p) : p[15:0];
	endfunction : mcp_wave

	function automatic logic [31:0] mcp_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			mcp_merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction : mcp_merge

	function automatic logic [15:0] mcp_dwell_load(input logic [1:0] md, input logic [7:0] t);
		mcp_dwell_load = md[1] ? {t, 8'h00} : {8'h00, t};
	endfunction : mcp_dwell_load

	mcp_div u_len_div (
		.clock(clock),
		.reset_n(reset_n),
		.start(!d1_busy),
		.dividend({9'h000, s_q.cnts}),
		.divisor({16'h0000, s_q.cyc}),
		.busy(d1_busy),
		.done(d1_done),
		.quot(d1_quot)
	);

	mcp_div u_ang_div (
		.clock(clock),
		.reset_n(reset_n),
		.start(!d2_busy),
		.dividend({s_q.pos, 8'h00}),
		.divisor(s_q.len),
		.busy(d2_busy),
		.done(d2_done),
		.quot(d2_quot)
	);

	always_comb
	begin
		s_d = s_q;
		// Taken while waitrequest is high; a write lands at the edge where it is seen low
		acc = (avs_read || avs_write) && !s_q.wait_n;
		wr = avs_write && s_q.wait_n;
		wd = 32'h0000_0000;
		need = (s_q.slip == 23'h00_0000) && (s_q.abs_addr == 16'h0000);
		s_d.wait_n = acc;
		s_d.cmd = 1'b0;
		unique case (avs_address)
			`MCP_A_CTRL: s_d.rdata = {27'h000_0000, 1'b0, s_q.cloop, s_q.mode, s_q.en};
			`MCP_A_CYCLES: s_d.rdata = {24'h00_0000, s_q.cyc};
			`MCP_A_COUNTS: s_d.rdata = {9'h000, s_q.cnts};
			`MCP_A_SPACING: s_d.rdata = {24'h00_0000, s_q.spc};
			`MCP_A_MAG: s_d.rdata = {16'h0000, s_q.mag};
			`MCP_A_DWELL: s_d.rdata = {24'h00_0000, s_q.dwell};
			`MCP_A_ABS: s_d.rdata = {16'h0000, s_q.abs_addr};
			`MCP_A_SLIP: s_d.rdata = {9'h000, s_q.slip};
			`MCP_A_STATUS: s_d.rdata = {28'h000_0000, s_q.len_ok, need, s_q.phased, s_q.srch};
			`MCP_A_LEN: s_d.rdata = {8'h00, s_q.len};
			`MCP_A_POS: s_d.rdata = {8'h00, s_q.pos};
			default: s_d.rdata = 32'h0000_0000;
		endcase
		if (!acc)
			s_d.rdata = 32'h0000_0000;
		if (wr)
		begin
			unique case (avs_address)
				`MCP_A_CTRL:
				begin
					wd = mcp_merge({27'h000_0000, 1'b0, s_q.cloop, s_q.mode, s_q.en},
						avs_writedata, avs_byteenable);
					s_d.en = wd[`MCP_B_ENABLE];
					s_d.mode = wd[`MCP_B_MODE_HI:`MCP_B_MODE_LO];
					s_d.cloop = wd[`MCP_B_CLOOP];
					s_d.cmd = wd[`MCP_B_PHASE_CMD];
				end
				`MCP_A_CYCLES:
				begin
					wd = mcp_merge({24'h00_0000, s_q.cyc}, avs_writedata, avs_byteenable);
					s_d.cyc = wd[7:0];
					s_d.len_ok = 1'b0;
				end
				`MCP_A_COUNTS:
				begin
					wd = mcp_merge({9'h000, s_q.cnts}, avs_writedata, avs_byteenable);
					s_d.cnts = wd[22:0];
					s_d.len_ok = 1'b0;
				end
				`MCP_A_SPACING:
				begin
					wd = mcp_merge({24'h00_0000, s_q.spc}, avs_writedata, avs_byteenable);
					s_d.spc = wd[7:0];
				end
				`MCP_A_MAG:
				begin
					wd = mcp_merge({16'h0000, s_q.mag}, avs_writedata, avs_byteenable);
					s_d.mag = wd[15:0];
				end
				`MCP_A_DWELL:
				begin
					wd = mcp_merge({24'h00_0000, s_q.dwell}, avs_writedata, avs_byteenable);
					s_d.dwell = wd[7:0];
				end
				`MCP_A_ABS:
				begin
					wd = mcp_merge({16'h0000, s_q.abs_addr}, avs_writedata, avs_byteenable);
					s_d.abs_addr = wd[15:0];
				end
				`MCP_A_SLIP:
				begin
					wd = mcp_merge({9'h000, s_q.slip}, avs_writedata, avs_byteenable);
					s_d.slip = wd[22:0];
				end
				default:
				begin
					wd = 32'h0000_0000;
				end
			endcase
		end
		// Length is only trusted once a division finished on current settings
		if (d1_done && !(wr && (avs_address == `MCP_A_CYCLES || avs_address == `MCP_A_COUNTS)))
		begin
			s_d.len = d1_quot[23:0];
			// A run begun before a settings write fails the product check and is dropped
			s_d.len_ok = (s_q.cyc != 8'h00) && (d1_quot[31:23] == 9'h000)
				&& (d1_quot[22:0] != 23'h00_0000)
				&& (32'(d1_quot[22:0]) * 32'(s_q.cyc) <= 32'(s_q.cnts))
				&& ((32'(d1_quot[22:0]) + 32'h0000_0001) * 32'(s_q.cyc) > 32'(s_q.cnts));
		end
		if (d2_done && s_q.len_ok)
			s_d.ang = d2_quot[7:0];
		// Feedback is used in whatever count units the decoder produces
		delta = fb_count - s_q.fb_last;
		np = {1'b0, s_q.pos} + {delta[23], delta};
		if (servo_tick)
		begin
			s_d.fb_last = fb_count;
			if (s_q.len_ok)
			begin
				if (np[24])
					np = np + {1'b0, s_q.len};
				else if (np[23:0] >= s_q.len)
					np = np - {1'b0, s_q.len};
				s_d.pos = np[23:0];
			end
		end
		if (!s_q.len_ok)
			s_d.pos = 24'h00_0000;
		go = 1'b0;
		if (s_q.en && s_q.armed)
		begin
			s_d.armed = 1'b0;
			go = s_q.mode[0];
		end
		if (s_q.cmd)
			go = 1'b1;
		unique case (s_q.st)
			MCP_IDLE:
			begin
				if (go && s_q.en && need)
				begin
					s_d.phased = 1'b0;
					if (s_q.dwell == 8'h00)
						s_d.phased = 1'b1;
					else
					begin
						s_d.st = s_q.mode[1] ? MCP_STEP_A : MCP_GUESS1;
						s_d.tmr = mcp_dwell_load(s_q.mode, s_q.dwell);
						s_d.fb_mark = fb_count;
					end
				end
			end
			MCP_GUESS1, MCP_STEP_A:
			begin
				if (servo_tick)
				begin
					s_d.tmr = s_q.tmr - 16'h0001;
					if (s_q.tmr == 16'h0001)
					begin
						s_d.st = (s_q.st == MCP_GUESS1) ? MCP_GUESS2 : MCP_STEP_B;
						s_d.tmr = mcp_dwell_load(s_q.mode, s_q.dwell);
						s_d.m1_neg = (fb_count - s_q.fb_mark) >= 24'h80_0000;
						s_d.fb_mark = fb_count;
					end
				end
			end
			MCP_GUESS2, MCP_STEP_B:
			begin
				if (servo_tick)
				begin
					s_d.tmr = s_q.tmr - 16'h0001;
					if (s_q.tmr == 16'h0001)
					begin
						s_d.st = MCP_IDLE;
						s_d.phased = 1'b1;
						s_d.pos = 24'h00_0000;
						// Quadrant of the rotor from the two movement directions
						if (s_q.st == MCP_GUESS2)
							s_d.ofs = {(fb_count - s_q.fb_mark) >= 24'h80_0000,
								s_q.m1_neg ^ ((fb_count - s_q.fb_mark) >= 24'h80_0000),
								6'h00};
						else
							s_d.ofs = 8'h00;
					end
				end
			end
		endcase
		if (!s_q.en)
			s_d.st = MCP_IDLE;
		s_d.srch = (s_d.st != MCP_IDLE);
		drive_ang = s_q.ang + s_q.ofs;
		drive_mag = torque_cmd;
		if (s_q.st == MCP_GUESS1 || s_q.st == MCP_GUESS2)
		begin
			drive_ang = (s_q.st == MCP_GUESS1) ? 8'h00 : `MCP_GUESS_B;
			drive_mag = s_q.mag;
		end
		s_d.pa = mcp_wave(drive_ang, drive_mag);
		// Second output leads by the spacing; the mirrored value reverses rotation
		s_d.pb = mcp_wave(8'(drive_ang + s_q.spc), drive_mag);
		if (s_q.st == MCP_STEP_A || s_q.st == MCP_STEP_B)
		begin
			s_d.pa = (s_q.st == MCP_STEP_A) ? s_q.mag : 16'h0000;
			s_d.pb = 16'(-s_q.mag);
		end
		// No torque reaches an unphased synchronous motor
		if (!s_q.en || (s_q.st == MCP_IDLE && need && !s_q.phased) || !s_q.len_ok)
		begin
			s_d.pa = 16'h0000;
			s_d.pb = 16'h0000;
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q <= '0;
			s_q.cyc <= `MCP_RST_CYCLES;
			s_q.cnts <= `MCP_RST_COUNTS;
			s_q.spc <= `MCP_RST_SPACING;
			s_q.mag <= `MCP_RST_MAG;
			s_q.dwell <= `MCP_RST_DWELL;
			s_q.armed <= 1'b1;
			s_q.st <= MCP_IDLE;
		end
		else
			s_q <= s_d;
	end

	assign avs_waitrequest = !s_q.wait_n;
	assign avs_readdata = s_q.rdata;
	assign phase_a_cmd = s_q.pa;
	assign phase_b_cmd = s_q.pb;
	assign phasing_active = s_q.srch;

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered in one cycle");
	AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_LEN: assert property (s_q.len_ok |->
		32'(s_q.len) * 32'(s_q.cyc) <= 32'(s_q.cnts)
		&& 32'(s_q.len + 24'h00_0001) * 32'(s_q.cyc) > 32'(s_q.cnts))
		else $error("cycle length is not counts over cycles");
	AST_POS_WRAP: assert property (s_q.len_ok |-> s_q.pos < s_q.len)
		else $error("phase position outside the cycle");
	AST_AUTO: assert property (s_q.st != MCP_IDLE && $past(s_q.st) == MCP_IDLE
		&& !$past(s_q.cmd) |-> $past(s_q.mode[0]) && $past(s_q.armed))
		else $error("search started without power-on mode or command");
	AST_DWELL: assert property ($past(s_q.st) == MCP_IDLE && s_q.st != MCP_IDLE
		|-> s_q.tmr == mcp_dwell_load($past(s_q.mode), $past(s_q.dwell)))
		else $error("dwell not loaded at search start");
	AST_STEP_A: assert property (s_q.st == MCP_STEP_A && s_q.len_ok && s_q.en |=>
		phase_a_cmd == $past(s_q.mag) && phase_b_cmd == 16'(-$past(s_q.mag)))
		else $error("stepper lock outputs wrong");
	AST_GUESS_MAG: assert property (s_q.st == MCP_GUESS1 && s_q.len_ok
		&& s_q.en |=> phase_a_cmd == 16'h0000
		&& phase_b_cmd == mcp_wave($past(s_q.spc), $past(s_q.mag)))
		else $error("first guess output wrong");
	AST_NO_TORQUE: assert property (s_q.en && need && !s_q.phased
		&& s_q.st == MCP_IDLE |=> phase_a_cmd == 16'h0000 && phase_b_cmd == 16'h0000)
		else $error("torque applied before phasing");

	COV_GUESS_DONE: cover property (s_q.st == MCP_GUESS2 ##1 s_q.st == MCP_IDLE);
	COV_STEP_DONE: cover property (s_q.st == MCP_STEP_B ##1 s_q.st == MCP_IDLE);
	COV_READ: cover property (avs_read && !avs_waitrequest);
endmodule : mcp_top
`default_nettype wire
